// ===== logic/ecp_pkg.sv
// Purpose: Shared constants and types for the endpoint calibration and duty output block
// Assumes: 40 MHz core clock
// Notes: Times kept in their own unit, cycle counts derived from them
package ecp_pkg;
  // ********************
  // Clock and timing
  // ********************
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned PWM_HZ = 100000;
  localparam int unsigned PWM_PERIOD_CYC = CLK_HZ / PWM_HZ;
  localparam int unsigned CAL_PULSE_US = 2500;
  localparam int unsigned CAL_PULSE_CYC = (CAL_PULSE_US * (CLK_HZ / 1000000));
  localparam int unsigned POWERUP_MS = 200;
  localparam int unsigned POWERUP_CYC = POWERUP_MS * (CLK_HZ / 1000);
  localparam int unsigned CAL_BURSTS = 15;
  localparam int unsigned DUTY_MAX = 255;

  // ********************
  // Reset values
  // ********************
  localparam logic [15:0] RST_LOW_EP = 16'h0000;
  localparam logic [15:0] RST_HIGH_EP = 16'hFFFF;
  localparam logic [7:0] RST_DUTY = 8'h00;

  typedef enum logic [4:0] {
    ECP_ST_HOLDOFF = 5'h01,
    ECP_ST_RUN = 5'h02,
    ECP_ST_QUAL = 5'h04,
    ECP_ST_ACQ = 5'h08,
    ECP_ST_WAITLOW = 5'h10
  } ecp_state_type;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } ecp_sample_type;

  typedef struct packed {
    logic req;
    logic [15:0] data;
  } ecp_nvm_wr_type;
endpackage

// ===== logic/ecp_duty_gen.sv
// Purpose: Fixed-period duty-cycle generator, 8-bit code
// Assumes: Period in clock cycles set by parameter
// Notes: New code is taken only at a period boundary to avoid runt pulses
`timescale 1ns/1ps
`default_nettype none
module ecp_duty_gen
  import ecp_pkg::*;
#(
  parameter int unsigned PERIOD = PWM_PERIOD_CYC
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic [7:0] code_i,
  output logic pwm_o
);
  localparam int CW = $clog2(PERIOD);
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic [7:0] code_ff, nxt_code;
  logic pwm_ff, nxt_pwm;
  logic [CW+7:0] thr;

  always_comb begin
    thr = (CW+8)'(code_ff) * (CW+8)'(PERIOD) / (CW+8)'(DUTY_MAX);
    nxt_cnt = (cnt_ff == CW'(PERIOD - 1)) ? '0 : cnt_ff + CW'(1);
    nxt_code = (cnt_ff == CW'(PERIOD - 1)) ? code_i : code_ff;
    nxt_pwm = en_i && ((CW+8)'(cnt_ff) < thr);
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_ff <= '0;
      code_ff <= RST_DUTY;
      pwm_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      code_ff <= nxt_code;
      pwm_ff <= nxt_pwm;
    end
  end

  assign pwm_o = pwm_ff;
endmodule
`default_nettype wire

// ===== logic/ecp_top.sv
// Purpose: Endpoint learning and scaled duty-cycle output of a capacitance converter
// Assumes: Samples arrive one per acquisition burst; nonvolatile store is external
// Notes: Learn pins are open-drain style high drivers; enable low means driving
// Summary of operation
// - Output square wave at 100 kHz
// - Result encoded as high-time duty cycle
// - Duty frozen during calibration, updated after
// - Low learn captures minimum endpoint
// - High learn captures maximum endpoint
// - Span between endpoints fills full range
// - Either endpoint may be learned first
// - Relearn replaces only that endpoint
// - Device drives learn high after 2.5 ms
// - Fifteen bursts averaged per calibration
// - Release learn pin when calibration done
// - Store endpoint after pin low, resume
// - 200 ms power-up hold-off, learn ignored
// - Eight-bit code, 0 low to 255 high
`timescale 1ns/1ps
`default_nettype none
module ecp_top
  import ecp_pkg::*;
#(
  parameter int unsigned HOLDOFF_CYC = POWERUP_CYC,
  parameter int unsigned QUAL_CYC = CAL_PULSE_CYC,
  parameter int unsigned NBURST = CAL_BURSTS
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire ecp_sample_type sample_i,
  input wire logic [15:0] nvm_low_i,
  input wire logic [15:0] nvm_high_i,
  input wire logic nvm_load_i,
  input wire logic low_endpoint_learn_i,
  output logic low_endpoint_learn_o,
  output logic low_endpoint_learn_oe_n_o,
  input wire logic high_endpoint_learn_i,
  output logic high_endpoint_learn_o,
  output logic high_endpoint_learn_oe_n_o,
  output ecp_nvm_wr_type nvm_low_wr_o,
  output ecp_nvm_wr_type nvm_high_wr_o,
  output logic cal_busy_o,
  output logic pwm_o
);
  // ********************
  // Learn pin synchronisers
  // ********************
  logic [1:0] s1_ff, s2_ff;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_ff <= 2'h0;
      s2_ff <= 2'h0;
    end else begin
      s1_ff <= {high_endpoint_learn_i, low_endpoint_learn_i};
      s2_ff <= s1_ff;
    end
  end

  // ********************
  // Sequencer
  // ********************
  localparam int HW = $clog2(HOLDOFF_CYC + 1);
  localparam int QW = $clog2(QUAL_CYC + 1);
  localparam int BW = $clog2(NBURST + 1);
  ecp_state_type st_ff, nxt_st;
  logic [HW-1:0] hold_ff, nxt_hold;
  logic [QW-1:0] q_ff, nxt_q;
  logic [BW-1:0] b_ff, nxt_b;
  logic [19:0] acc_ff, nxt_acc;
  logic sel_ff, nxt_sel;
  logic [15:0] lo_ff, nxt_lo, hi_ff, nxt_hi;
  logic [7:0] duty_ff, nxt_duty;
  logic drv_ff, nxt_drv;
  logic en_ff, nxt_en;
  ecp_nvm_wr_type wl_ff, nxt_wl, wh_ff, nxt_wh;
  logic pin;
  logic [15:0] avg;
  logic [16:0] span, off;
  logic [24:0] scaled;

  always_comb begin
    pin = sel_ff ? s2_ff[1] : s2_ff[0];
    avg = 16'((acc_ff + 20'(NBURST / 2)) / 20'(NBURST));
    nxt_st = st_ff;
    nxt_hold = hold_ff;
    nxt_q = q_ff;
    nxt_b = b_ff;
    nxt_acc = acc_ff;
    nxt_sel = sel_ff;
    nxt_lo = lo_ff;
    nxt_hi = hi_ff;
    nxt_drv = drv_ff;
    nxt_en = en_ff;
    nxt_wl = '{req: 1'b0, data: lo_ff};
    nxt_wh = '{req: 1'b0, data: hi_ff};
    if (nvm_load_i && st_ff == ECP_ST_HOLDOFF) begin
      nxt_lo = nvm_low_i;
      nxt_hi = nvm_high_i;
    end
    unique case (st_ff)
      ECP_ST_HOLDOFF: begin
        // Pins ignored and output idle until supply settles
        if (hold_ff == HW'(HOLDOFF_CYC - 1)) begin
          nxt_st = ECP_ST_RUN;
          nxt_en = 1'b1;
        end else begin
          nxt_hold = hold_ff + HW'(1);
        end
      end
      ECP_ST_RUN: begin
        nxt_q = '0;
        if (s2_ff[0] || s2_ff[1]) begin
          nxt_sel = !s2_ff[0];
          nxt_st = ECP_ST_QUAL;
        end
      end
      ECP_ST_QUAL: begin
        // Short glitches drop back without a calibration
        if (!pin) begin
          nxt_st = ECP_ST_RUN;
        end else if (q_ff == QW'(QUAL_CYC - 2)) begin
          nxt_drv = 1'b1;
          nxt_b = '0;
          nxt_acc = '0;
          nxt_st = ECP_ST_ACQ;
        end else begin
          nxt_q = q_ff + QW'(1);
        end
      end
      ECP_ST_ACQ: begin
        if (sample_i.valid) begin
          nxt_acc = acc_ff + 20'(sample_i.data);
          if (b_ff == BW'(NBURST - 1)) begin
            nxt_drv = 1'b0;
            nxt_st = ECP_ST_WAITLOW;
          end
          nxt_b = b_ff + BW'(1);
        end
      end
      ECP_ST_WAITLOW: begin
        if (!pin) begin
          if (sel_ff) begin
            nxt_hi = avg;
            nxt_wh = '{req: 1'b1, data: avg};
          end else begin
            nxt_lo = avg;
            nxt_wl = '{req: 1'b1, data: avg};
          end
          nxt_st = ECP_ST_RUN;
        end
      end
    endcase
  end

  // ********************
  // Scaling to 8-bit code
  // ********************
  always_comb begin
    span = (hi_ff > lo_ff) ? 17'(hi_ff) - 17'(lo_ff) : 17'h00001;
    off = '0;
    if (sample_i.data > lo_ff) begin
      off = 17'(sample_i.data) - 17'(lo_ff);
    end
    if (off > span) begin
      off = span;
    end
    scaled = (25'(off) * 25'(DUTY_MAX)) / 25'(span);
    nxt_duty = duty_ff;
    // Frozen while a learn cycle runs so the host sees the old result
    if (st_ff == ECP_ST_RUN && sample_i.valid) begin
      nxt_duty = 8'(scaled);
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= ECP_ST_HOLDOFF;
      hold_ff <= '0;
      q_ff <= '0;
      b_ff <= '0;
      acc_ff <= '0;
      sel_ff <= 1'b0;
      lo_ff <= RST_LOW_EP;
      hi_ff <= RST_HIGH_EP;
      duty_ff <= RST_DUTY;
      drv_ff <= 1'b0;
      en_ff <= 1'b0;
      wl_ff <= '0;
      wh_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      hold_ff <= nxt_hold;
      q_ff <= nxt_q;
      b_ff <= nxt_b;
      acc_ff <= nxt_acc;
      sel_ff <= nxt_sel;
      lo_ff <= nxt_lo;
      hi_ff <= nxt_hi;
      duty_ff <= nxt_duty;
      drv_ff <= nxt_drv;
      en_ff <= nxt_en;
      wl_ff <= nxt_wl;
      wh_ff <= nxt_wh;
    end
  end

  // Drive only high; never pull low so host contention is harmless
  assign low_endpoint_learn_o = 1'b1;
  assign high_endpoint_learn_o = 1'b1;
  assign low_endpoint_learn_oe_n_o = !(drv_ff && !sel_ff);
  assign high_endpoint_learn_oe_n_o = !(drv_ff && sel_ff);
  assign nvm_low_wr_o = wl_ff;
  assign nvm_high_wr_o = wh_ff;
  assign cal_busy_o = (st_ff != ECP_ST_RUN) && (st_ff != ECP_ST_HOLDOFF);

  ecp_duty_gen #(
    .PERIOD(PWM_PERIOD_CYC)
  ) u_gen (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .en_i(en_ff),
    .code_i(duty_ff),
    .pwm_o(pwm_o)
  );

  // ********************
  // Assertions
  // ********************
  property p_holdoff;
    @(posedge mclk_i) disable iff (!nrst_i)
      (st_ff == ECP_ST_HOLDOFF)
        |-> (!pwm_o && low_endpoint_learn_oe_n_o && high_endpoint_learn_oe_n_o);
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("activity during hold-off");

  property p_freeze;
    @(posedge mclk_i) disable iff (!nrst_i)
      (st_ff != ECP_ST_RUN) |=> (duty_ff == $past(duty_ff));
  endproperty
  a_freeze: assert property (p_freeze) else $error("duty moved during calibration");

  property p_drive;
    @(posedge mclk_i) disable iff (!nrst_i)
      (st_ff == ECP_ST_QUAL && pin && q_ff == QW'(QUAL_CYC - 2)) |=> drv_ff;
  endproperty
  a_drive: assert property (p_drive) else $error("learn pin not held");

  property p_qual_drop;
    @(posedge mclk_i) disable iff (!nrst_i)
      (st_ff == ECP_ST_QUAL && !pin) |=> (st_ff == ECP_ST_RUN && !drv_ff);
  endproperty
  a_qual_drop: assert property (p_qual_drop) else $error("short learn pulse accepted");

  property p_release;
    @(posedge mclk_i) disable iff (!nrst_i)
      (st_ff == ECP_ST_WAITLOW) |-> !drv_ff;
  endproperty
  a_release: assert property (p_release) else $error("learn pin not released");

  property p_bursts;
    @(posedge mclk_i) disable iff (!nrst_i)
      (st_ff == ECP_ST_ACQ && $past(st_ff) != ECP_ST_ACQ)
        |-> ($past(st_ff) == ECP_ST_QUAL && b_ff == '0 && acc_ff == '0);
  endproperty
  a_bursts: assert property (p_bursts) else $error("acquisition started unclean");

  property p_count;
    @(posedge mclk_i) disable iff (!nrst_i)
      (st_ff == ECP_ST_WAITLOW) |-> (b_ff == BW'(NBURST));
  endproperty
  a_count: assert property (p_count) else $error("wrong burst count");

  property p_store;
    @(posedge mclk_i) disable iff (!nrst_i)
      (st_ff == ECP_ST_WAITLOW && !pin) |=> (wl_ff.req ^ wh_ff.req) && st_ff == ECP_ST_RUN;
  endproperty
  a_store: assert property (p_store) else $error("endpoint not stored");

  property p_keep_other;
    @(posedge mclk_i) disable iff (!nrst_i)
      wh_ff.req |-> (lo_ff == $past(lo_ff));
  endproperty
  a_keep_other: assert property (p_keep_other) else $error("other endpoint changed");

  property p_keep_high;
    @(posedge mclk_i) disable iff (!nrst_i)
      wl_ff.req |-> (hi_ff == $past(hi_ff));
  endproperty
  a_keep_high: assert property (p_keep_high) else $error("upper endpoint changed");

  property p_range;
    @(posedge mclk_i) disable iff (!nrst_i)
      (st_ff == ECP_ST_RUN && sample_i.valid && sample_i.data >= hi_ff && hi_ff > lo_ff)
        |=> (duty_ff == 8'hFF);
  endproperty
  a_range: assert property (p_range) else $error("full scale not reached");

  c_low: cover property (@(posedge mclk_i) disable iff (!nrst_i) wl_ff.req);
  c_high: cover property (@(posedge mclk_i) disable iff (!nrst_i) wh_ff.req);
  c_glitch: cover property (@(posedge mclk_i) disable iff (!nrst_i)
    st_ff == ECP_ST_QUAL ##1 st_ff == ECP_ST_RUN);
  c_frozen: cover property (@(posedge mclk_i) disable iff (!nrst_i)
    st_ff == ECP_ST_ACQ && sample_i.valid);
endmodule
`default_nettype wire

// ===== verification/ecp_host_model.sv
// Purpose: Host side of the two learn pins, with their pull-downs
// Assumes: Host only drives a pin high or releases it
// Notes: Pin level is the wired-OR of all high drivers
`timescale 1ns/1ps
`default_nettype none
module ecp_host_model (
  input wire logic low_drv_i,
  input wire logic high_drv_i,
  input wire logic dev_low_i,
  input wire logic dev_low_oe_n_i,
  input wire logic dev_high_i,
  input wire logic dev_high_oe_n_i,
  output logic low_pin_o,
  output logic high_pin_o
);
  // ********************
  // Pin resolution
  // ********************
  // Nobody ever pulls low; a released pin falls to the pull-down
  assign low_pin_o = low_drv_i | (~dev_low_oe_n_i & dev_low_i);
  assign high_pin_o = high_drv_i | (~dev_high_oe_n_i & dev_high_i);
endmodule
`default_nettype wire

// ===== verification/ecp_top_tb.sv
// Purpose: Self-checking bench for endpoint learning and duty output
// Assumes: Short hold-off and qualify counts via parameters
// Notes: Outputs sampled on the falling edge to stay clear of races
`timescale 1ns/1ps
`default_nettype none
module ecp_top_tb;
  import ecp_pkg::*;
  localparam int unsigned HO = 50;
  localparam int unsigned QC = 20;
  logic mclk_i, nrst_i, nvm_load, lo_drv, hi_drv, lo_pin, hi_pin;
  logic lo_o, lo_oe_n, hi_o, hi_oe_n, busy, pwm;
  ecp_sample_type smp;
  ecp_nvm_wr_type lo_wr, hi_wr;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  ecp_top #(.HOLDOFF_CYC(HO), .QUAL_CYC(QC), .NBURST(CAL_BURSTS)) ecp_top_inst (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .sample_i(smp), .nvm_low_i(16'h0800),
    .nvm_high_i(16'h1800), .nvm_load_i(nvm_load), .low_endpoint_learn_i(lo_pin),
    .low_endpoint_learn_o(lo_o), .low_endpoint_learn_oe_n_o(lo_oe_n),
    .high_endpoint_learn_i(hi_pin), .high_endpoint_learn_o(hi_o),
    .high_endpoint_learn_oe_n_o(hi_oe_n), .nvm_low_wr_o(lo_wr), .nvm_high_wr_o(hi_wr),
    .cal_busy_o(busy), .pwm_o(pwm));
  ecp_host_model ecp_host_model_inst (
    .low_drv_i(lo_drv), .high_drv_i(hi_drv), .dev_low_i(lo_o), .dev_low_oe_n_i(lo_oe_n),
    .dev_high_i(hi_o), .dev_high_oe_n_i(hi_oe_n), .low_pin_o(lo_pin), .high_pin_o(hi_pin));
  // ********************
  // Clock and watchdog
  // ********************
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // ********************
  // Shared tasks
  // ********************
  task automatic end_of_test();
    $display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic send(input logic [15:0] d);
    @(posedge mclk_i);
    smp <= '{valid: 1'b1, data: d};
    @(posedge mclk_i);
    smp.valid <= 1'b0;
    repeat (4) @(posedge mclk_i);
  endtask
  // Two whole periods: high count and number of rising edges
  task automatic check_duty(input int code);
    int hi;
    int rises;
    logic prev;
    hi = 0;
    rises = 0;
    @(negedge mclk_i);
    prev = pwm;
    repeat (2 * PWM_PERIOD_CYC) begin
      @(negedge mclk_i);
      if (pwm === 1'b1) hi++;
      if (pwm === 1'b1 && prev === 1'b0) rises++;
      prev = pwm;
    end
    chk("pwm high cycles", 2 * (code * PWM_PERIOD_CYC / DUTY_MAX), hi);
    chk("pwm rising edges", (code == 0 || code == 255) ? 0 : 2, rises);
  endtask
  // ********************
  // Scenarios
  // ********************
  task automatic holdoff();
    int bad;
    bad = 0;
    @(posedge mclk_i);
    nvm_load <= 1'b1;
    lo_drv <= 1'b1;
    hi_drv <= 1'b1;
    smp <= '{valid: 1'b1, data: 16'h8000};
    repeat (HO - 8) begin
      @(negedge mclk_i);
      if (lo_oe_n !== 1'b1 || hi_oe_n !== 1'b1 || pwm !== 1'b0 || busy !== 1'b0) bad++;
    end
    @(posedge mclk_i);
    lo_drv <= 1'b0;
    hi_drv <= 1'b0;
    nvm_load <= 1'b0;
    smp.valid <= 1'b0;
    chk("hold-off activity", 0, bad);
    repeat (20) @(posedge mclk_i);
  endtask
  // Pulse shorter than the qualify time must not start a learn
  task automatic short_pulse();
    int bad;
    bad = 0;
    @(posedge mclk_i);
    lo_drv <= 1'b1;
    repeat (QC / 2) @(posedge mclk_i);
    lo_drv <= 1'b0;
    repeat (QC + 10) begin
      @(negedge mclk_i);
      if (lo_oe_n !== 1'b1 || lo_wr.req !== 1'b0) bad++;
    end
    chk("short pulse ignored", 0, bad);
    chk("busy after short pulse", 0, busy);
  endtask
  // Host pulse slightly longer than the qualify time, then release
  task automatic learn(input bit up, input logic [15:0] d, input int frz);
    int n;
    ecp_nvm_wr_type wr;
    n = 0;
    @(posedge mclk_i);
    if (up) hi_drv <= 1'b1;
    else lo_drv <= 1'b1;
    @(negedge mclk_i);
    while ((up ? hi_oe_n : lo_oe_n) !== 1'b0 && n < QC + 20) begin
      @(negedge mclk_i);
      n++;
    end
    chk("qualify window", 1, n >= QC && n < QC + 20);
    repeat (QC / 5) @(posedge mclk_i);
    if (up) hi_drv <= 1'b0;
    else lo_drv <= 1'b0;
    repeat (3) @(negedge mclk_i);
    chk("pin held by device", 1, up ? hi_pin : lo_pin);
    chk("busy during learn", 1, busy);
    repeat (7) send(d);
    if (frz >= 0) check_duty(frz);
    repeat (CAL_BURSTS - 8) send(d);
    @(negedge mclk_i);
    chk("pin held before last burst", 0, up ? hi_oe_n : lo_oe_n);
    // Last burst inline: the store pulse follows within a few cycles
    @(posedge mclk_i);
    smp <= '{valid: 1'b1, data: d};
    @(posedge mclk_i);
    smp.valid <= 1'b0;
    @(negedge mclk_i);
    chk("pin released", 1, up ? hi_oe_n : lo_oe_n);
    chk("pin floats low", 0, up ? hi_pin : lo_pin);
    n = 0;
    wr = up ? hi_wr : lo_wr;
    while (wr.req !== 1'b1 && n < 12) begin
      @(negedge mclk_i);
      wr = up ? hi_wr : lo_wr;
      n++;
    end
    chk("store request", 1, wr.req);
    chk("stored endpoint", d, wr.data);
    @(negedge mclk_i);
    chk("store pulse width", 0, up ? hi_wr.req : lo_wr.req);
    chk("other store idle", 0, up ? lo_wr.req : hi_wr.req);
    repeat (3) @(negedge mclk_i);
    chk("busy after store", 0, busy);
  endtask
  task automatic scaled(input logic [15:0] d, input int code);
    send(d);
    repeat (2 * PWM_PERIOD_CYC) @(posedge mclk_i);
    check_duty(code);
  endtask
  // ********************
  // Main sequence
  // ********************
  initial begin
    nrst_i = 1'b0;
    nvm_load = 1'b0;
    lo_drv = 1'b0;
    hi_drv = 1'b0;
    smp = '{valid: 1'b0, data: 16'h0000};
    repeat (3) @(posedge mclk_i);
    nrst_i <= 1'b1;
    holdoff();
    scaled(16'h1000, 127);
    short_pulse();
    learn(1'b1, 16'h1FF0, -1);
    learn(1'b0, 16'h1000, -1);
    scaled(16'h1330, 51);
    scaled(16'h1FF0, 255);
    scaled(16'h1330, 51);
    learn(1'b1, 16'h2FE0, 51);
    scaled(16'h1660, 51);
    scaled(16'h1000, 0);
    end_of_test();
  end
endmodule
`default_nettype wire
